// ==== ssdl_pkg.sv ====
package ssdl_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int SSDL_ADDR_W = 8;
  localparam logic [SSDL_ADDR_W-1:0] SSDL_OFF_CTRL = 8'h00;
  localparam logic [SSDL_ADDR_W-1:0] SSDL_OFF_DATA = 8'h04;
  localparam logic [7:0] SSDL_CTRL_RST = 8'h00;
  localparam logic [7:0] SSDL_DATA_RST = 8'h00;
  localparam logic [23:0] SSDL_RD_PAD = 24'h000000;

  // ---------------------------------------------------------------
  // bit framing
  // ---------------------------------------------------------------
  localparam logic [3:0] SSDL_LAST_BIT = 4'h7;
  localparam logic [3:0] SSDL_ACK_BIT = 4'h8;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int SSDL_CLK_MHZ = 100;
  localparam int SSDL_SCL_HALF_NS = 5000;
  // least time, so round up to whole cycles
  localparam int SSDL_HALF_CYC = (SSDL_SCL_HALF_NS * SSDL_CLK_MHZ + 999) / 1000;
  localparam int SSDL_TMR_W = 12;

  // master sequencer, gray along idle-start-run-stop
  typedef enum logic [2:0] {
    M_IDLE  = 3'h0,
    M_START = 3'h1,
    M_RUN   = 3'h3,
    M_STOP1 = 3'h2,
    M_STOP2 = 3'h6,
    M_STOP3 = 3'h7,
    M_RS1   = 3'h5,
    M_RS2   = 3'h4
  } ssdl_mst_e;

  // control and status register layout, bit 7 first
  typedef struct packed {
    logic master;
    logic tx;
    logic start_flag;
    logic stop_flag;
    logic ack_request_flag;
    logic arb;
    logic ack;
    logic si;
  } ssdl_ctrl_s;

  // conditions seen on the synchronised bus
  typedef struct packed {
    logic rise;
    logic fall;
    logic start;
    logic stop;
  } ssdl_cond_s;

endpackage

// ==== ssdl_core.sv ====
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - master indicator sets on generated start, clears on generated stop or lost arbitration
// - transmit indicator sets on generated start or data written before the frame
// - transmit indicator clears on start seen, lost arbitration, or data left unwritten
// - start flag sets when start plus address byte arrive; only software clears it
// - stop flag sets when a stop is seen while addressed as slave
// - stop flag sets when arbitration is lost to a stop on the bus
// - stop flag clears once the requested master stop is on the bus
// - ack request sets on each received byte, clears after each ack cycle
// - arbitration lost on repeated start seen as master with start flag low
// - arbitration lost when scl is low while making a stop or repeated start
// - arbitration lost when sda is low while sending a one, outside ack bits
// - arbitration lost flag clears each time the interrupt flag is cleared
// - ack bit sets when the incoming ack is low
// - ack bit clears when the incoming ack is high
// - interrupt on start made, arbitration lost, byte sent with ack received
// - interrupt on byte received, start plus address received, stop received
// - data shifts out msb first; first received bit lands in msb
// - bus data shifts in while data shifts out; register holds last byte
// - lost arbitration drops to slave receiver keeping the byte in the register
// - receiver sends the software ack value; unwritten ack gives a nack
// - scl held low while the interrupt flag stays set
// - stop request makes a stop after next ack; with start too, stop then start
// - start request makes master mode and a start once the bus is free
module ssdl_core
  import ssdl_pkg::*;
#(
  parameter int HALF_CYC = SSDL_HALF_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // two-wire pins, enable high pulls the line low
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);

  localparam logic [SSDL_TMR_W-1:0] HALF_LD = SSDL_TMR_W'(HALF_CYC - 1);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [1:0] scl_sync_r, sda_sync_r;
  logic scl_s, sda_s, scl_d_r, sda_d_r;
  ssdl_cond_s cond;
  logic dp_wr_r;
  logic [SSDL_ADDR_W-1:0] dp_addr_r;
  ssdl_ctrl_s stat, wctl;
  logic sw_ctrl_wr, sw_data_wr, sw_si_clr;
  logic master_r, tx_r, sta_r, sto_r, ack_request_flag_r, arb_r, ack_r, si_r;
  logic wr_pend_r, dec_pend_r, hold_r;
  logic busy_r, skip_r, out_bit_r, first_r, addr_r, ign_r, bnd_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  ssdl_mst_e m_state_r;
  logic [SSDL_TMR_W-1:0] tmr_r;
  logic m_scl_low_r, m_sda_low_r;
  logic part, live, smp, shifting, tmr_done, m_ctrl, eng_sda_low;
  logic ev_rx_byte, ev_ack_end, ev_tx_ack, ev_ack_smp, ev_dec_late, do_dec;
  logic ev_gen_start, ev_gen_stop, ev_slv_stop, start_ok;
  logic arb_sda, arb_rs, arb_stop, arb_scl, ev_arb;

  function automatic logic hit(input logic [SSDL_ADDR_W-1:0] a,
                               input logic [SSDL_ADDR_W-1:0] off);
    return a == off;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers and bus conditions
  // ---------------------------------------------------------------
  // idle bus is high, so the chain resets high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_i};
      sda_sync_r <= {sda_sync_r[0], sda_i};
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // edge detection only looks at the second stage
  assign scl_s = scl_sync_r[1];
  assign sda_s = sda_sync_r[1];
  assign cond.rise = scl_s & ~scl_d_r;
  assign cond.fall = ~scl_s & scl_d_r;
  assign cond.start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign cond.stop = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ---------------------------------------------------------------
  // ahb-lite register slave
  // ---------------------------------------------------------------
  // zero wait states; read data is captured in the address phase
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dp_wr_r <= 1'b0;
      dp_addr_r <= '0;
      hrdata <= 32'h00000000;
    end else if (hready) begin
      dp_wr_r <= hsel & htrans[1] & hwrite;
      dp_addr_r <= haddr[SSDL_ADDR_W-1:0];
      if (hsel & htrans[1] & ~hwrite) begin
        if (hit(haddr[SSDL_ADDR_W-1:0], SSDL_OFF_CTRL))
          hrdata <= {SSDL_RD_PAD, stat};
        else if (hit(haddr[SSDL_ADDR_W-1:0], SSDL_OFF_DATA))
          hrdata <= {SSDL_RD_PAD, shift_r};
        else
          hrdata <= 32'h00000000;
      end else begin
        hrdata <= 32'h00000000;
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign sw_ctrl_wr = dp_wr_r & hit(dp_addr_r, SSDL_OFF_CTRL);
  assign sw_data_wr = dp_wr_r & hit(dp_addr_r, SSDL_OFF_DATA);
  assign wctl = ssdl_ctrl_s'(hwdata[7:0]);
  assign sw_si_clr = sw_ctrl_wr & ~wctl.si & si_r;
  assign stat = '{master: master_r, tx: tx_r, start_flag: sta_r, stop_flag: sto_r,
                  ack_request_flag: ack_request_flag_r, arb: arb_r, ack: ack_r, si: si_r};

  // ---------------------------------------------------------------
  // event decode
  // ---------------------------------------------------------------
  assign part = master_r | addr_r | (first_r & ~ign_r);
  assign live = busy_r & ~skip_r;
  assign smp = cond.rise & live;
  assign shifting = smp & (bit_cnt_r < SSDL_ACK_BIT);
  assign tmr_done = (tmr_r == '0);
  // sequencer owns sda when not idle, outside the data and ack bits of a frame
  assign m_ctrl = (m_state_r != M_IDLE) & ~((m_state_r == M_RUN) & ~skip_r);
  assign ev_rx_byte = cond.fall & live & (bit_cnt_r == SSDL_LAST_BIT) & ~tx_r & part;
  assign ev_ack_end = cond.fall & live & (bit_cnt_r == SSDL_ACK_BIT);
  assign ev_tx_ack = ev_ack_end & tx_r & part;
  assign ev_ack_smp = smp & (bit_cnt_r == SSDL_ACK_BIT) & tx_r & part;
  assign ev_dec_late = dec_pend_r & ~si_r;
  assign do_dec = (ev_ack_end & ~ev_tx_ack) | ev_dec_late;
  assign ev_gen_start = (m_state_r == M_START) & tmr_done & scl_s;
  assign ev_gen_stop = (m_state_r == M_STOP3) & cond.stop;
  assign ev_slv_stop = cond.stop & addr_r & ~master_r;
  assign start_ok = (m_state_r == M_IDLE) & sta_r & ~busy_r & ~si_r & scl_s & sda_s;
  assign arb_sda = shifting & tx_r & part & out_bit_r & ~sda_s & ~m_ctrl;
  assign arb_rs = cond.start & master_r & ~sta_r;
  assign arb_stop = cond.stop & master_r & (m_state_r != M_STOP3);
  assign arb_scl = ((m_state_r == M_STOP3) | (m_state_r == M_START)) & ~scl_s;
  assign ev_arb = arb_sda | arb_rs | arb_stop | arb_scl;

  // ---------------------------------------------------------------
  // mode indicators
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      master_r <= 1'b0;
      tx_r <= 1'b0;
    end else begin
      if (ev_gen_stop | ev_arb)
        master_r <= 1'b0;
      else if (ev_gen_start)
        master_r <= 1'b1;
      if (ev_arb)
        tx_r <= 1'b0;
      else if (ev_gen_start)
        tx_r <= 1'b1;
      else if (cond.start)
        tx_r <= 1'b0;
      else if (do_dec)
        tx_r <= wr_pend_r;
    end
  end

  // ---------------------------------------------------------------
  // start, stop and acknowledge flags
  // ---------------------------------------------------------------
  // hardware events win over a software write in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sta_r <= 1'b0;
      sto_r <= 1'b0;
      ack_request_flag_r <= 1'b0;
      ack_r <= 1'b0;
    end else begin
      if (ev_rx_byte & first_r & ~master_r)
        sta_r <= 1'b1;
      else if (sw_ctrl_wr)
        sta_r <= wctl.start_flag;
      if (ev_slv_stop | arb_stop)
        sto_r <= 1'b1;
      else if (ev_gen_stop)
        sto_r <= 1'b0;
      else if (sw_ctrl_wr)
        sto_r <= wctl.stop_flag;
      if (ev_rx_byte)
        ack_request_flag_r <= 1'b1;
      else if (ev_ack_end)
        ack_request_flag_r <= 1'b0;
      if (ev_rx_byte)
        ack_r <= 1'b0;
      else if (ev_ack_smp)
        ack_r <= ~sda_s;
      else if (sw_ctrl_wr)
        ack_r <= wctl.ack;
    end
  end

  // ---------------------------------------------------------------
  // interrupt flag, stall and deferred decisions
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      si_r <= 1'b0;
      arb_r <= 1'b0;
      dec_pend_r <= 1'b0;
      wr_pend_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      if (ev_rx_byte | ev_tx_ack | ev_gen_start | ev_arb | ev_slv_stop)
        si_r <= 1'b1;
      else if (sw_ctrl_wr)
        si_r <= wctl.si;
      if (ev_arb)
        arb_r <= 1'b1;
      else if (sw_si_clr)
        arb_r <= 1'b0;
      // decide the next byte only after software has had its say
      if (ev_arb)
        dec_pend_r <= 1'b0;
      else if (ev_tx_ack | ev_gen_start)
        dec_pend_r <= 1'b1;
      else if (ev_dec_late)
        dec_pend_r <= 1'b0;
      if (sw_data_wr)
        wr_pend_r <= 1'b1;
      else if (do_dec)
        wr_pend_r <= 1'b0;
      // grab scl only once it is already low, so no false edge;
      // let go only after the deferred bit has reached sda
      if (~si_r & ~dec_pend_r)
        hold_r <= 1'b0;
      else if (si_r & ~scl_s & busy_r)
        hold_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // bit engine
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
      skip_r <= 1'b0;
      bit_cnt_r <= 4'h0;
      first_r <= 1'b0;
      addr_r <= 1'b0;
      ign_r <= 1'b0;
      bnd_r <= 1'b0;
    end else if (cond.stop) begin
      busy_r <= 1'b0;
      first_r <= 1'b0;
      addr_r <= 1'b0;
      bnd_r <= 1'b0;
    end else if (cond.start) begin
      busy_r <= 1'b1;
      skip_r <= 1'b1;
      bit_cnt_r <= 4'h0;
      first_r <= 1'b1;
      addr_r <= 1'b0;
      ign_r <= 1'b0;
      bnd_r <= 1'b0;
    end else if (cond.fall & busy_r) begin
      // the fall right after a start is not a bit boundary
      if (skip_r) begin
        skip_r <= 1'b0;
      end else if (bit_cnt_r == SSDL_ACK_BIT) begin
        bit_cnt_r <= 4'h0;
        bnd_r <= 1'b1;
        if (first_r) begin
          first_r <= 1'b0;
          // a nacked address mutes slave events until next start
          if (~master_r) begin
            addr_r <= ack_r;
            ign_r <= ~ack_r;
          end
        end
      end else begin
        bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
      end
    end else if (cond.rise) begin
      bnd_r <= 1'b0;
    end
  end

  // next outgoing bit, loaded while scl is low
  always_ff @(posedge clk) begin
    if (sys_rst)
      out_bit_r <= 1'b1;
    else if (cond.start)
      out_bit_r <= 1'b0;
    else if (do_dec)
      out_bit_r <= shift_r[7];
    else if (cond.fall & live & (bit_cnt_r < SSDL_LAST_BIT))
      out_bit_r <= shift_r[7];
  end

  // ---------------------------------------------------------------
  // shift data register
  // ---------------------------------------------------------------
  // bus shift wins; software must stay off it mid-byte
  always_ff @(posedge clk) begin
    if (sys_rst)
      shift_r <= SSDL_DATA_RST;
    else if (shifting)
      shift_r <= {shift_r[6:0], sda_s};
    else if (sw_data_wr)
      shift_r <= hwdata[7:0];
  end

  // ---------------------------------------------------------------
  // master sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      m_state_r <= M_IDLE;
      tmr_r <= '0;
      m_scl_low_r <= 1'b0;
      m_sda_low_r <= 1'b0;
    end else if (ev_arb) begin
      m_state_r <= M_IDLE;
      m_scl_low_r <= 1'b0;
      m_sda_low_r <= 1'b0;
    end else begin
      if (~tmr_done)
        tmr_r <= tmr_r - 1'b1;
      case (m_state_r)
        M_IDLE: begin
          if (start_ok) begin
            m_sda_low_r <= 1'b1;
            tmr_r <= HALF_LD;
            m_state_r <= M_START;
          end
        end
        M_START: begin
          if (ev_gen_start) begin
            m_scl_low_r <= 1'b1;
            tmr_r <= HALF_LD;
            m_state_r <= M_RUN;
          end
        end
        M_RUN: begin
          if (m_scl_low_r) begin
            if (tmr_done & ~si_r & ~dec_pend_r) begin // sda settles first
              if (bnd_r & sto_r) begin
                m_sda_low_r <= 1'b1;
                tmr_r <= HALF_LD;
                m_state_r <= M_STOP1;
              end else if (bnd_r & sta_r) begin
                m_sda_low_r <= 1'b0;
                tmr_r <= HALF_LD;
                m_state_r <= M_RS1;
              end else begin
                m_scl_low_r <= 1'b0;
              end
            end
          end else if (cond.rise) begin
            // high time counts from the seen rise, so stretching works
            tmr_r <= HALF_LD;
          end else if (tmr_done & scl_s) begin
            m_scl_low_r <= 1'b1;
            tmr_r <= HALF_LD;
          end
        end
        M_STOP1: begin
          if (tmr_done) begin
            m_scl_low_r <= 1'b0;
            tmr_r <= HALF_LD;
            m_state_r <= M_STOP2;
          end
        end
        M_STOP2: begin
          if (tmr_done & scl_s) begin
            m_sda_low_r <= 1'b0;
            m_state_r <= M_STOP3;
          end
        end
        M_STOP3: begin
          if (cond.stop)
            m_state_r <= M_IDLE;
        end
        M_RS1: begin
          if (tmr_done) begin
            m_scl_low_r <= 1'b0;
            tmr_r <= HALF_LD;
            m_state_r <= M_RS2;
          end
        end
        M_RS2: begin
          if (tmr_done & scl_s) begin
            m_sda_low_r <= 1'b1;
            tmr_r <= HALF_LD;
            m_state_r <= M_START;
          end
        end
        default: m_state_r <= M_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  assign eng_sda_low = busy_r & part &
      (((bit_cnt_r < SSDL_ACK_BIT) & tx_r & ~out_bit_r) |
       ((bit_cnt_r == SSDL_ACK_BIT) & ~tx_r & ack_r));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_oe <= m_scl_low_r | hold_r;
      sda_oe <= m_ctrl ? m_sda_low_r : eng_sda_low;
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_stop_req;
    m_state_r == M_RUN && m_scl_low_r && tmr_done && !si_r && !dec_pend_r && bnd_r && sto_r;
  endsequence
  sequence s_stop_out;
    m_state_r == M_STOP1 ##1 sda_oe;
  endsequence

  chk_master_start: assert property (
      ev_gen_start && !ev_arb |=> master_r && tx_r && si_r)
    else $error("start made without master, transmit and interrupt");
  chk_master_drop: assert property (
      ev_gen_stop || ev_arb |=> !master_r)
    else $error("master kept after stop or lost arbitration");
  chk_tx_clear: assert property (
      (cond.start || ev_arb) && !ev_gen_start |=> !tx_r)
    else $error("transmit kept after start seen");
  chk_addr_flags: assert property (
      ev_rx_byte && first_r && !master_r |=> sta_r && ack_request_flag_r)
    else $error("address byte did not raise start and ack request");
  chk_slave_stop: assert property (
      ev_slv_stop |=> sto_r && si_r)
    else $error("slave stop not flagged");
  chk_arb_stop: assert property (
      arb_stop |=> sto_r && arb_r)
    else $error("stop loss not flagged");
  chk_stop_done: assert property (
      ev_gen_stop && !ev_slv_stop |=> !sto_r)
    else $error("stop flag kept after stop made");
  chk_ack_request_flag_end: assert property (
      ev_ack_end |=> !ack_request_flag_r)
    else $error("ack request kept after ack cycle");
  chk_arb_set: assert property (
      ev_arb |=> arb_r && si_r && !master_r && !tx_r)
    else $error("lost arbitration not flagged");
  chk_arb_clear: assert property (
      sw_si_clr && !ev_arb |=> !arb_r)
    else $error("arbitration flag kept after interrupt clear");
  chk_ack_sample: assert property (
      ev_ack_smp |=> ack_r == !$past(sda_s))
    else $error("ack bit not taken from bus");
  chk_shift_in: assert property (
      shifting |=> shift_r == {$past(shift_r[6:0]), $past(sda_s)})
    else $error("bus bit not shifted into lsb");
  chk_arb_keep: assert property (
      ev_arb && !shifting && !sw_data_wr |=> $stable(shift_r))
    else $error("data lost on arbitration");
  chk_nack_default: assert property (
      ev_rx_byte |=> !ack_r ##1 (!$past(sw_ctrl_wr) || ack_r == $past(wctl.ack)))
    else $error("receiver ack not defaulted to nack");
  chk_ack_drive: assert property (
      busy_r && part && !tx_r && !m_ctrl && bit_cnt_r == SSDL_ACK_BIT && ack_r |=> sda_oe)
    else $error("receiver ack not driven low on sda");
  chk_scl_stall: assert property (
      si_r && hold_r |=> scl_oe)
    else $error("scl released while stalled");
  chk_stop_gen: assert property (
      s_stop_req |=> s_stop_out)
    else $error("stop request not sent");
  chk_start_gen: assert property (
      start_ok && !ev_arb |=> m_state_r == M_START ##1 sda_oe)
    else $error("start request not sent");
  chk_late_dec: assert property (
      ev_dec_late && !ev_arb && !cond.start && !ev_gen_start |=> tx_r == $past(wr_pend_r))
    else $error("resume ignored software writes");

endmodule

// ==== ssdl_bus_partner.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------
// far side of the two-wire bus, master or slave
// ---------------------------------------------------------------
module ssdl_bus_partner (
  // wire levels
  input wire logic scl,
  input wire logic sda,
  // pull-down enables, high pulls the line low
  output logic scl_pd,
  output logic sda_pd
);
  // lines released, so the pull-ups hold them high between frames
  initial begin
    scl_pd = 1'b0;
    sda_pd = 1'b0;
  end
  // one master clock pulse; waits out any stretch by the block
  task automatic m_bit(input logic b, output logic r);
    sda_pd = !b;
    #40 scl_pd = 1'b0;
    while (!scl) #10;
    #20 r = sda;
    #20 scl_pd = 1'b1;
  endtask
  // start then one byte msb first, ack slot left to the caller
  task automatic m_start(input logic [7:0] v);
    logic r;
    sda_pd = 1'b1;
    #40 scl_pd = 1'b1;
    for (int i = 7; i >= 0; i--) m_bit(v[i], r);
  endtask
  task automatic m_stop;
    sda_pd = 1'b1;
    #40 scl_pd = 1'b0;
    #40 sda_pd = 1'b0;
    #80;
  endtask
  // slave that takes one byte from the block and acks it
  task automatic s_rx(output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(posedge scl);
      d = {d[6:0], sda};
    end
    @(negedge scl);
    #20 sda_pd = 1'b1;
    @(negedge scl);
    #20 sda_pd = 1'b0;
  endtask
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top
  import ssdl_pkg::*;
;
  logic clk, sys_rst, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, hr_q, rd;
  logic scl_oe, sda_oe, p_scl, p_sda, r;
  logic [7:0] v, d;
  int fail_count = 0;
  int checked = 0;
  wire scl = !(scl_oe | p_scl);
  wire sda = !(sda_oe | p_sda);
  ssdl_core #(.HALF_CYC(8)) dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scl_i(scl), .scl_o(),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
  ssdl_bus_partner p (.scl(scl), .sda(sda), .scl_pd(p_scl), .sda_pd(p_sda));
  // read data as it stood before each edge, free of update races
  always @(posedge clk) hr_q <= hrdata;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [7:0] ctl(logic m, logic t, logic sa, logic rq, logic ak, logic s);
    ssdl_ctrl_s c;
    c = '{m, t, sa, 1'b0, rq, 1'b0, ak, s};
    return c;
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // single word transfer; each phase ends at an edge with hready high
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    #1 rd = hr_q;
  endtask
  task automatic wait_si;
    for (int i = 0; i < 400; i++) begin
      ahb(1'b0, SSDL_OFF_CTRL, 32'h0);
      if (rd[0] === 1'b1) return;
    end
    fail_count++;
    report_and_stop();
  endtask
  // a hung bus ends the run with a mismatch
  initial begin
    #800us;
    fail_count++;
    report_and_stop();
  end
  initial begin
    {sys_rst, hsel, hwrite} = 3'h4;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    void'($urandom(91));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    ahb(1'b0, SSDL_OFF_CTRL, 32'h0);
    chk("ctrl reset", {SSDL_RD_PAD, SSDL_CTRL_RST}, rd);
    chk("okay response", 32'h0, {31'h0, hresp});
    ahb(1'b0, SSDL_OFF_DATA, 32'h0);
    chk("data reset", {SSDL_RD_PAD, SSDL_DATA_RST}, rd);
    ahb(1'b0, 8'h0C, 32'h0);
    chk("unmapped", 32'h0, rd);
    // slave receive: first address acked by software, second nacked by writing the ack bit low
    for (int k = 0; k < 2; k++) begin
      v = {8'($urandom()) & 8'hFE};
      p.m_start(v);
      wait_si();
      chk("addr ctrl", {24'h0, ctl(0, 0, 1, 1, 0, 1)}, rd);
      ahb(1'b0, SSDL_OFF_DATA, 32'h0);
      chk("addr data", {24'h0, v}, rd);
      fork
        p.m_bit(1'b1, r);
        ahb(1'b1, SSDL_OFF_CTRL, (k == 0) ? 32'h02 : 32'h00);
      join
      chk("ack slot", {31'h0, k[0]}, {31'h0, r});
      // the ack fall needs a few cycles to pass the synchronisers
      repeat (4) @(posedge clk);
      ahb(1'b0, SSDL_OFF_CTRL, 32'h0);
      chk("ack_request_flag low", 32'h0, {31'h0, rd[3]});
      p.m_stop();
      if (k == 0) begin
        wait_si();
        chk("stop seen", 32'h11, rd & 32'h11);
      end
      ahb(1'b1, SSDL_OFF_CTRL, 32'h0);
    end
    // block as master transmitter, partner acks
    v = 8'($urandom());
    fork
      p.s_rx(d);
      begin
        ahb(1'b1, SSDL_OFF_CTRL, 32'h20);
        wait_si();
        chk("start made", {24'h0, ctl(1, 1, 1, 0, 0, 1)}, rd);
        ahb(1'b1, SSDL_OFF_DATA, {24'h0, v});
        ahb(1'b1, SSDL_OFF_CTRL, 32'h0);
        wait_si();
        chk("byte sent", 32'h83, rd & 32'h87);
      end
    join
    chk("wire byte", {24'h0, v}, {24'h0, d});
    ahb(1'b1, SSDL_OFF_CTRL, 32'h10);
    for (int i = 0; i < 200; i++) begin
      ahb(1'b0, SSDL_OFF_CTRL, 32'h0);
      if ((rd & 32'h90) == 0) break;
    end
    chk("stop made", 32'h0, rd & 32'h91);
    report_and_stop();
  end
endmodule
